// File: core/monitor_config_and_alert_mask_regs.sv
// Purpose: offset, configuration two and alert mask registers of a hardware monitor
// Assumes: AXI4-Lite slave on aclk; status sources and fan flags from monitor logic
// Notes:   byte address = register index * 4; unmapped addresses answer SLVERR
//
// Operation
// - add remote two offset to each result
// - lock bit makes offset, config two read-only
// - presence enable makes bits 3:1 show fans
// - read-only four-wire flags for fans one-three
// - averaging disable converts sixteen times faster
// - attenuator bypass removes four input attenuators
// - single channel mode converts one chosen input
// - mask one bits 0-3 gate voltage alerts
// - mask one bits 4-6 gate temperature alerts
// - override clear, all masked: status two still alerts
// - override set, all masked: status two silent
// - mask two gates per-source status two alerts
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "monitor_regs_cfg.svh"
module monitor_config_and_alert_mask_regs #(
  parameter int AVG_COUNT = `AVG_SAMPLES
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // fan presence pins, one per fan speed input
  input  wire logic [2:0]  fan_four_wire_pin,
  // remote two conversion results
  input  wire logic        remote_two_raw_valid,
  input  wire logic [7:0]  remote_two_raw_temp,
  output logic             remote_two_adj_valid,
  output logic [7:0]       remote_two_adj_temp,
  // out-of-limit events from the limit comparators
  input  wire logic [7:0]  status_one_event,
  input  wire logic [7:0]  status_two_event,
  // measurement control
  output logic             averaging_disable,
  output logic             attenuator_bypass_2v5,
  output logic             attenuator_bypass_core,
  output logic             attenuator_bypass_5v,
  output logic             attenuator_bypass_12v,
  output logic             single_channel_convert,
  output logic [2:0]       single_channel_select,
  output logic [4:0]       samples_per_result,
  // alert
  output logic             smbalert_n
);

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  logic [7:0] remote_two_temp_offset_reg;
  logic [7:0] config_two_reg;
  logic [7:0] alert_mask_one_reg;
  logic [7:0] alert_mask_two_reg;
  logic [7:0] config_one_reg;
  logic [7:0] config_four_reg;
  logic [7:0] config_five_reg;
  logic [7:0] fan_one_min_high_reg;
  logic [7:0] status_one_reg;
  logic [7:0] status_two_reg;
  logic [7:0] remote_two_temp_reg;
  logic [2:0] fan_flags;

  monitor_regs_pkg::wr_state_t wr_state_reg;
  monitor_regs_pkg::rd_state_t rd_state_reg;
  logic [31:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        aw_held_reg;
  logic        w_held_reg;

  initial begin
    if (AVG_COUNT < 1 || AVG_COUNT > 16) $error("AVG_COUNT must be 1 to 16");
  end

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [7:0] reg_index(input logic [31:0] addr);
    reg_index = addr[9:2];
  endfunction : reg_index

  function automatic logic is_mapped(input logic [7:0] idx);
    case (idx)
      `IDX_REMOTE_TWO_TEMP_OFFSET, `IDX_CONFIG_TWO, `IDX_ALERT_MASK_ONE,
      `IDX_ALERT_MASK_TWO, `IDX_CONFIG_ONE, `IDX_CONFIG_FOUR,
      `IDX_CONFIG_FIVE, `IDX_FAN_ONE_MIN_HIGH, `IDX_STATUS_ONE,
      `IDX_STATUS_TWO, `IDX_REMOTE_TWO_TEMP: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // --------------------------------------------------------------------------
  // pin synchronisation of fan detection
  // --------------------------------------------------------------------------
  pin_sync #(
    .WIDTH    (3)
  ) u_fan_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (fan_four_wire_pin),
    .sync_out (fan_flags)
  );

  // --------------------------------------------------------------------------
  // write channel
  // --------------------------------------------------------------------------
  logic [7:0] wr_idx;
  logic       wr_fire;
  logic       locked;

  assign wr_idx  = reg_index(awaddr_reg);
  assign wr_fire = (wr_state_reg == monitor_regs_pkg::wr_idle) && aw_held_reg && w_held_reg;
  assign locked  = config_one_reg[`CFG1_LOCK_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= '0;
      wdata_reg     <= '0;
      wstrb_reg     <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      // ready only while a slot is free, so each channel is taken once
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= monitor_regs_pkg::wr_idle;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_RESP_OKAY;
    end else begin
      unique case (wr_state_reg)
        monitor_regs_pkg::wr_idle: begin
          if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= is_mapped(wr_idx) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            wr_state_reg <= monitor_regs_pkg::wr_resp;
          end
        end
        monitor_regs_pkg::wr_resp: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_state_reg <= monitor_regs_pkg::wr_hold;
          end
        end
        monitor_regs_pkg::wr_hold: begin
          wr_state_reg <= monitor_regs_pkg::wr_idle;
        end
        default: begin
          wr_state_reg <= monitor_regs_pkg::wr_idle;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // register writes, low byte lane only
  // --------------------------------------------------------------------------
  logic wr_byte;
  assign wr_byte = wr_fire && wstrb_reg[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remote_two_temp_offset_reg <= `RST_BYTE;
      config_two_reg             <= `RST_BYTE;
      alert_mask_one_reg         <= `RST_BYTE;
      alert_mask_two_reg         <= `RST_BYTE;
      config_one_reg             <= `RST_BYTE;
      config_four_reg            <= `RST_BYTE;
      config_five_reg            <= `RST_BYTE;
      fan_one_min_high_reg       <= `RST_BYTE;
    end else if (wr_byte) begin
      // writes under lock are acknowledged but dropped
      if (wr_idx == `IDX_REMOTE_TWO_TEMP_OFFSET && !locked) begin
        remote_two_temp_offset_reg <= wdata_reg[7:0];
      end
      // flags and reserved bit are not software-writable
      if (wr_idx == `IDX_CONFIG_TWO && !locked) begin
        config_two_reg <= (wdata_reg[7:0] & `CFG2_SW_MASK) | (config_two_reg & ~`CFG2_SW_MASK);
      end
      if (wr_idx == `IDX_ALERT_MASK_ONE) begin
        alert_mask_one_reg <= wdata_reg[7:0];
      end
      if (wr_idx == `IDX_ALERT_MASK_TWO) begin
        alert_mask_two_reg <= wdata_reg[7:0];
      end
      // lock is sticky until reset
      if (wr_idx == `IDX_CONFIG_ONE) begin
        config_one_reg <= wdata_reg[7:0] | (config_one_reg & (8'h01 << `CFG1_LOCK_BIT));
      end
      if (wr_idx == `IDX_CONFIG_FOUR) begin
        config_four_reg <= wdata_reg[7:0];
      end
      if (wr_idx == `IDX_CONFIG_FIVE) begin
        config_five_reg <= wdata_reg[7:0];
      end
      if (wr_idx == `IDX_FAN_ONE_MIN_HIGH) begin
        fan_one_min_high_reg <= wdata_reg[7:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // status recording, clear on read, set wins
  // --------------------------------------------------------------------------
  logic rd_fire;
  logic [7:0] rd_idx;
  assign rd_idx  = reg_index(s_axi_araddr);
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_one_reg <= `RST_BYTE;
      status_two_reg <= `RST_BYTE;
    end else begin
      // recorded regardless of masks
      if (rd_fire && rd_idx == `IDX_STATUS_ONE) begin
        status_one_reg <= status_one_event;
      end else begin
        status_one_reg <= status_one_reg | status_one_event;
      end
      if (rd_fire && rd_idx == `IDX_STATUS_TWO) begin
        status_two_reg <= status_two_event;
      end else begin
        status_two_reg <= status_two_reg | status_two_event;
      end
    end
  end

  // --------------------------------------------------------------------------
  // read channel
  // --------------------------------------------------------------------------
  logic [7:0] config_two_view;
  always_comb begin
    config_two_view = config_two_reg;
    if (config_two_reg[`CFG2_PRESENCE_BIT]) begin
      config_two_view[`CFG2_FLAG_HI:`CFG2_FLAG_LO] = fan_flags;
    end
  end

  function automatic logic [7:0] read_mux(input logic [7:0] idx, input logic [7:0] cfg2);
    case (idx)
      `IDX_REMOTE_TWO_TEMP_OFFSET: read_mux = remote_two_temp_offset_reg;
      `IDX_CONFIG_TWO:             read_mux = cfg2;
      `IDX_ALERT_MASK_ONE:         read_mux = alert_mask_one_reg;
      `IDX_ALERT_MASK_TWO:         read_mux = alert_mask_two_reg;
      `IDX_CONFIG_ONE:             read_mux = config_one_reg;
      `IDX_CONFIG_FOUR:            read_mux = config_four_reg;
      `IDX_CONFIG_FIVE:            read_mux = config_five_reg;
      `IDX_FAN_ONE_MIN_HIGH:       read_mux = fan_one_min_high_reg;
      `IDX_STATUS_ONE:             read_mux = status_one_reg;
      `IDX_STATUS_TWO:             read_mux = status_two_reg;
      `IDX_REMOTE_TWO_TEMP:        read_mux = remote_two_temp_reg;
      default:                     read_mux = `RST_BYTE;
    endcase
  endfunction : read_mux

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_reg  <= monitor_regs_pkg::rd_idle;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `AXI_RESP_OKAY;
    end else begin
      unique case (rd_state_reg)
        monitor_regs_pkg::rd_idle: begin
          s_axi_arready <= !rd_fire;
          if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, read_mux(rd_idx, config_two_view)};
            s_axi_rresp  <= is_mapped(rd_idx) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            rd_state_reg <= monitor_regs_pkg::rd_data;
          end
        end
        monitor_regs_pkg::rd_data: begin
          if (s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
            rd_state_reg  <= monitor_regs_pkg::rd_idle;
          end
        end
        default: begin
          rd_state_reg <= monitor_regs_pkg::rd_idle;
          s_axi_rvalid <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // remote two offset path
  // --------------------------------------------------------------------------
  offset_adder #(
    .WIDTH        (8)
  ) u_offset (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .in_valid     (remote_two_raw_valid),
    .raw_temp     (remote_two_raw_temp),
    .offset       (remote_two_temp_offset_reg),
    .coarse_range (config_five_reg[`CFG5_OFFSET_RANGE_BIT]),
    .out_valid    (remote_two_adj_valid),
    .adj_temp     (remote_two_adj_temp)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remote_two_temp_reg <= `RST_BYTE;
    end else if (remote_two_adj_valid) begin
      remote_two_temp_reg <= remote_two_adj_temp;
    end
  end

  // --------------------------------------------------------------------------
  // measurement control outputs
  // --------------------------------------------------------------------------
  localparam logic [4:0] AVG_N = 5'(AVG_COUNT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      averaging_disable      <= 1'b0;
      samples_per_result     <= AVG_N;
      attenuator_bypass_2v5  <= 1'b0;
      attenuator_bypass_core <= 1'b0;
      attenuator_bypass_5v   <= 1'b0;
      attenuator_bypass_12v  <= 1'b0;
      single_channel_convert <= 1'b0;
      single_channel_select  <= 3'h0;
    end else begin
      averaging_disable      <= config_two_reg[`CFG2_AVG_BIT];
      samples_per_result     <= config_two_reg[`CFG2_AVG_BIT] ? 5'h01 : AVG_N;
      // global bypass or per-channel bypass from config four
      attenuator_bypass_2v5  <= config_two_reg[`CFG2_ATTENUATOR_BYPASS_BIT] | config_four_reg[`CFG4_BYPASS_LO];
      attenuator_bypass_core <= config_two_reg[`CFG2_ATTENUATOR_BYPASS_BIT] | config_four_reg[`CFG4_BYPASS_LO+1];
      attenuator_bypass_5v   <= config_two_reg[`CFG2_ATTENUATOR_BYPASS_BIT] | config_four_reg[`CFG4_BYPASS_LO+2];
      attenuator_bypass_12v  <= config_two_reg[`CFG2_ATTENUATOR_BYPASS_BIT] | config_four_reg[`CFG4_BYPASS_HI];
      single_channel_convert <= config_two_reg[`CFG2_SINGLE_CHANNEL_CONVERT_BIT];
      single_channel_select  <= fan_one_min_high_reg[`FAN1_CHAN_HI:`FAN1_CHAN_LO];
    end
  end

  // --------------------------------------------------------------------------
  // alert generation
  // --------------------------------------------------------------------------
  logic one_alert;
  logic two_alert;
  logic two_all_masked;

  // bit 7 of status one never raises an alert; the override gates only the all-masked status two alert
  assign one_alert      = |(status_one_reg[6:0] & ~alert_mask_one_reg[6:0]);
  assign two_all_masked = &alert_mask_two_reg;
  assign two_alert      = (|(status_two_reg & ~alert_mask_two_reg))
                        | (two_all_masked && (|status_two_reg)
                           && !alert_mask_one_reg[`MASK1_OVERRIDE_BIT]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smbalert_n <= 1'b1;
    end else begin
      smbalert_n <= !(one_alert || two_alert);
    end
  end

endmodule : monitor_config_and_alert_mask_regs
`default_nettype wire

// File: core/monitor_regs_cfg.svh
// Purpose: constants for the monitor configuration and alert mask register slice
// Assumes: included by bare name from design files
// Notes:   byte offsets are the register addresses times four
`ifndef MONITOR_REGS_CFG_SVH
`define MONITOR_REGS_CFG_SVH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_REMOTE_TWO_TEMP_OFFSET 8'h72
`define IDX_CONFIG_TWO             8'h73
`define IDX_ALERT_MASK_ONE         8'h74
`define IDX_ALERT_MASK_TWO         8'h75
`define IDX_CONFIG_ONE             8'h40
`define IDX_CONFIG_FIVE            8'h7c
`define IDX_CONFIG_FOUR            8'h7d
`define IDX_FAN_ONE_MIN_HIGH       8'h55
`define IDX_STATUS_ONE             8'h41
`define IDX_STATUS_TWO             8'h42
`define IDX_REMOTE_TWO_TEMP        8'h27

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RST_BYTE                   8'h00

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CFG1_LOCK_BIT              1
`define CFG5_OFFSET_RANGE_BIT      1
`define CFG2_PRESENCE_BIT          0
`define CFG2_FLAG_LO               1
`define CFG2_FLAG_HI               3
`define CFG2_AVG_BIT               4
`define CFG2_ATTENUATOR_BYPASS_BIT              5
`define CFG2_SINGLE_CHANNEL_CONVERT_BIT              6
`define CFG2_RES_BIT               7
`define MASK1_OVERRIDE_BIT         7
`define CFG4_BYPASS_LO             4
`define CFG4_BYPASS_HI             7
`define FAN1_CHAN_LO               5
`define FAN1_CHAN_HI               7
`define CFG2_SW_MASK               8'h71

// ----------------------------------------------------------------------------
// averaging and bus answers
// ----------------------------------------------------------------------------
`define AVG_SAMPLES                16
`define AXI_RESP_OKAY              2'b00
`define AXI_RESP_SLVERR            2'b10

`endif

// File: core/monitor_regs_pkg.sv
// Purpose: shared types of the monitor register slice
// Assumes: nothing
// Notes:   constants live in monitor_regs_cfg.svh
package monitor_regs_pkg;

  typedef enum logic [2:0] {
    wr_idle = 3'b001,
    wr_resp = 3'b010,
    wr_hold = 3'b100
  } wr_state_t;

  typedef enum logic [1:0] {
    rd_idle = 2'b01,
    rd_data = 2'b10
  } rd_state_t;

endpackage : monitor_regs_pkg

// File: core/pin_sync.sv
// Purpose: two-flop synchroniser for a group of pin levels
// Assumes: inputs change slowly relative to aclk
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  initial begin
    if (WIDTH < 1) $error("pin_sync width must be positive");
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : pin_sync
`default_nettype wire

// File: core/offset_adder.sv
// Purpose: applies a signed offset to a temperature result
// Assumes: result and offset are two's complement, one cycle of latency
// Notes:   range bit doubles the offset step; output saturates
`timescale 1ns/1ps
`default_nettype none
module offset_adder #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // operands
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] raw_temp,
  input  wire logic [WIDTH-1:0] offset,
  input  wire logic             coarse_range,
  // result
  output logic                  out_valid,
  output logic      [WIDTH-1:0] adj_temp
);

  localparam logic signed [WIDTH+1:0] MAXV = (WIDTH+2)'(2**(WIDTH-1) - 1);
  localparam logic signed [WIDTH+1:0] MINV = -(WIDTH+2)'(2**(WIDTH-1));

  logic signed [WIDTH+1:0] sum;

  initial begin
    if (WIDTH < 2) $error("offset_adder width too small");
  end

  // coarse range steps the offset by twice the fine resolution
  always_comb begin
    sum = (WIDTH+2)'($signed(raw_temp));
    if (coarse_range) begin
      sum = sum + ((WIDTH+2)'($signed(offset)) <<< 1);
    end else begin
      sum = sum + (WIDTH+2)'($signed(offset));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid <= 1'b0;
      adj_temp  <= '0;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        if (sum > MAXV) begin
          adj_temp <= MAXV[WIDTH-1:0];
        end else if (sum < MINV) begin
          adj_temp <= MINV[WIDTH-1:0];
        end else begin
          adj_temp <= sum[WIDTH-1:0];
        end
      end
    end
  end

endmodule : offset_adder
`default_nettype wire

// File: test/alert_regs_monitor.sv
// Purpose: port assertions for the monitor register slice
// Assumes: one clock domain, aresetn synchronous active low
// Notes:   sees only top ports; attached by bind from the bench
`timescale 1ns/1ps
`default_nettype none
module alert_regs_monitor #(
  parameter int AVG_COUNT = 16
) (
  // clock and reset
  input wire logic        aclk, aresetn,
  // bus handshakes
  input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic        s_axi_rvalid, s_axi_rready,
  input wire logic [31:0] s_axi_araddr, s_axi_rdata,
  // datapath and control
  input wire logic        remote_two_raw_valid, remote_two_adj_valid, averaging_disable,
  input wire logic [4:0]  samples_per_result
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_adj_follows: assert property (
    remote_two_raw_valid |=> remote_two_adj_valid) else $error("adjusted result missing");
  a_adj_alone: assert property (
    remote_two_adj_valid |-> $past(remote_two_raw_valid)) else $error("adjusted result without input");
  a_avg_samples: assert property (
    $stable(averaging_disable) |-> samples_per_result == (averaging_disable ? 5'd1 : 5'(AVG_COUNT)))
    else $error("sample count wrong");
  a_flags_gated: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] == 8'h73
    |=> s_axi_rdata[0] || s_axi_rdata[3:1] == 3'h0) else $error("fan flags shown while disabled");
  a_wr_latency: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_b_single: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write response repeated");
  a_rd_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
  a_ar_refused: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
endmodule : alert_regs_monitor
`default_nettype wire

// File: test/tb_monitor_config_and_alert_mask_regs.sv
// Purpose: directed bench for the monitor register slice
// Assumes: fan pins static at 3'h5, bus timing per hand-over
// Notes:   lock is sticky until reset, so that scenario runs last
`timescale 1ns/1ps
`default_nettype none
module tb_monitor_config_and_alert_mask_regs;
  logic        aclk, aresetn;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [2:0]  fan_four_wire_pin, single_channel_select;
  logic        remote_two_raw_valid, remote_two_adj_valid, smbalert_n, averaging_disable;
  logic [7:0]  remote_two_raw_temp, remote_two_adj_temp, status_one_event, status_two_event;
  logic        attenuator_bypass_2v5, attenuator_bypass_core, attenuator_bypass_5v;
  logic        attenuator_bypass_12v, single_channel_convert;
  logic [4:0]  samples_per_result;
  int          n_fail, tests_run;

  monitor_config_and_alert_mask_regs i_dut (.*);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [39:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // a missing answer ends the run rather than hanging it
  task automatic hang(input logic ok);
    if (ok !== 1'b1) begin
      n_fail++;
      $display("MISMATCH %0t no answer", $time);
      summarize();
    end
  endtask : hang

  task automatic wr(input logic [7:0] idx, dat, input logic [1:0] er = 2'h0);
    int k;
    @(posedge aclk);
    s_axi_awaddr  <= {22'h0, idx, 2'h0};
    s_axi_wdata   <= {24'h0, dat};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      k++;
    end while (!s_axi_bvalid && k < 40);
    s_axi_bready <= 1'b0;
    hang(s_axi_bvalid);
    chk(s_axi_bresp, er);
  endtask : wr

  task automatic rd(input logic [7:0] idx, dat, input logic [1:0] er = 2'h0);
    int k;
    @(posedge aclk);
    s_axi_araddr  <= {22'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      k++;
    end while (!s_axi_rvalid && k < 40);
    s_axi_rready <= 1'b0;
    hang(s_axi_rvalid);
    chk({s_axi_rresp, s_axi_rdata}, {er, 24'h0, dat});
  endtask : rd

  task automatic ev(input logic [7:0] a, b);
    @(posedge aclk);
    status_one_event <= a;
    status_two_event <= b;
    @(posedge aclk);
    status_one_event <= 8'h0;
    status_two_event <= 8'h0;
    repeat (4) @(posedge aclk);
  endtask : ev

  task automatic offs(input logic [7:0] raw, exp);
    @(posedge aclk);
    remote_two_raw_valid <= 1'b1;
    remote_two_raw_temp  <= raw;
    @(posedge aclk);
    remote_two_raw_valid <= 1'b0;
    @(posedge aclk);
    chk({remote_two_adj_valid, remote_two_adj_temp}, {1'b1, exp});
  endtask : offs
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd(8'h72, 8'h00);
    rd(8'h73, 8'h00);
    rd(8'h74, 8'h00);
    chk({smbalert_n, samples_per_result}, {1'b1, 5'd16});
  endtask : t_reset

  task automatic t_cfg;
    wr(8'h73, 8'h7f);
    wr(8'h55, 8'ha0);
    rd(8'h73, 8'h7b);
    chk({averaging_disable, attenuator_bypass_2v5, attenuator_bypass_core, attenuator_bypass_5v,
         attenuator_bypass_12v, single_channel_convert}, 6'h3f);
    chk({samples_per_result, single_channel_select}, {5'd1, 3'h5});
    wr(8'h73, 8'h70);
    rd(8'h73, 8'h70);
  endtask : t_cfg

  task automatic t_offs;
    wr(8'h72, 8'h05);
    offs(8'h10, 8'h15);
    offs(8'h7e, 8'h7f);
    offs(8'hfe, 8'h03);
  endtask : t_offs

  task automatic t_alert;
    for (int i = 0; i < 7; i++) begin
      wr(8'h74, 8'h7f ^ (8'h1 << i));
      ev(8'h1 << i, 8'h0);
      chk(smbalert_n, 1'b0);
      rd(8'h41, 8'h1 << i);
    end
    wr(8'h74, 8'h7f);
    ev(8'h7f, 8'h0);
    chk(smbalert_n, 1'b1);
    rd(8'h41, 8'h7f);
    wr(8'h75, 8'hff);
    ev(8'h0, 8'h04);
    chk(smbalert_n, 1'b0);
    rd(8'h42, 8'h04);
    wr(8'h74, 8'hff);
    ev(8'h0, 8'h04);
    chk(smbalert_n, 1'b1);
    rd(8'h42, 8'h04);
    wr(8'h75, 8'h04);
    ev(8'h0, 8'h04);
    chk(smbalert_n, 1'b1);
    rd(8'h42, 8'h04);
  endtask : t_alert

  task automatic t_lock;
    wr(8'h10, 8'h11, 2'h2);
    rd(8'h10, 8'h00, 2'h2);
    wr(8'h40, 8'h02);
    wr(8'h72, 8'h33);
    rd(8'h72, 8'h05);
    wr(8'h73, 8'h01);
    rd(8'h73, 8'h70);
    wr(8'h74, 8'h11);
    rd(8'h74, 8'h11);
  endtask : t_lock

  initial begin
    n_fail = 0;
    tests_run = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, remote_two_raw_valid} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, remote_two_raw_temp, status_one_event, status_two_event} = '0;
    s_axi_wstrb = 4'h1;
    fan_four_wire_pin = 3'h5;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_cfg();
    t_offs();
    t_alert();
    t_lock();
    summarize();
  end
endmodule : tb_monitor_config_and_alert_mask_regs

bind monitor_config_and_alert_mask_regs alert_regs_monitor #(.AVG_COUNT(AVG_COUNT)) i_chk (.*);
`default_nettype wire
